/* File: rtl/lcd_pkg.sv */
// Shared constants, types and register map of the LCD multiplex RAM loader
package lcd_pkg;

    // ------------------------------------------------------------------
    // Display geometry and timing
    // ------------------------------------------------------------------
    localparam int NUM_COLS = 40;
    localparam int NUM_ROWS = 4;
    localparam int COL_W = 6;
    localparam int FRAME_DIV = 24;
    localparam int FRAME_CNT_W = 5;
    localparam logic [FRAME_CNT_W-1:0] FRAME_LAST = 5'h17;
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int INT_CLK_HZ = 1536;
    localparam int INT_CLK_DIV = SYS_CLK_HZ / INT_CLK_HZ;

    // ------------------------------------------------------------------
    // Drive modes, as encoded in the mode-set command
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_MUX4 = 2'h0,
        MODE_STATIC = 2'h1,
        MODE_MUX2 = 2'h2,
        MODE_MUX3 = 2'h3
    } drive_mode_e;

    localparam drive_mode_e RESET_MODE = MODE_MUX4;

    // ------------------------------------------------------------------
    // Transfer state: idle, command bytes, display data bytes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        XS_IDLE = 2'h0,
        XS_CMD = 2'h1,
        XS_DATA = 2'h3
    } xfer_state_e;

    // ------------------------------------------------------------------
    // Command byte fields
    // ------------------------------------------------------------------
    localparam int CMD_CONT_BIT = 7;
    localparam int CMD_PTR_SEL_BIT = 6;
    localparam logic [1:0] CMD_MODE_SET = 2'h2;
    localparam logic [3:0] CMD_DEV_SEL = 4'hC;
    localparam int CMD_EN_BIT = 3;

    // ------------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_BYTE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam int CTRL_START_BIT = 0;
    localparam int ST_PTR_LSB = 0;
    localparam int ST_SUB_LSB = 8;
    localparam int ST_MODE_LSB = 16;
    localparam int ST_EN_BIT = 18;
    localparam int ST_DATA_BIT = 19;
    localparam int ST_ACK_BIT = 20;
    localparam int ST_EXT_BIT = 21;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Frame timing carried from the timing block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic step;
        logic pol;
        logic [FRAME_CNT_W-1:0] cnt;
    } frame_s;

endpackage : lcd_pkg

/* File: rtl/lcd_clock_timing.sv */
// Clock source selection, frame counter and cascade synchronisation
module lcd_clock_timing
    import lcd_pkg::*;
#(
    parameter int INT_DIV = INT_CLK_DIV
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_osc_source_select,
    input wire logic i_clk_pin,
    input wire logic i_sync,
    output frame_s o_frame,
    output logic o_clk_pin,
    output logic o_clk_pin_oe,
    output logic o_sync,
    output logic o_sync_oe
);

    // ------------------------------------------------------------------
    // Clock ticks
    // ------------------------------------------------------------------
    localparam int DIV_W = $clog2(INT_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(INT_DIV / 2);

    logic [DIV_W-1:0] div_cnt;
    logic clk_pin_prev;
    logic [FRAME_CNT_W-1:0] frame_cnt;
    logic pol;
    logic step;

    wire int_tick = (div_cnt == DIV_LAST);
    wire ext_rise = i_clk_pin & ~clk_pin_prev;
    wire tick = i_osc_source_select ? ext_rise : int_tick;
    wire sync_pull = ~i_sync & ~o_sync_oe & (frame_cnt != '0);
    wire frame_wrap = (frame_cnt == FRAME_LAST);
    wire [FRAME_CNT_W-1:0] next_frame_cnt = sync_pull ? FRAME_CNT_W'(1) :
        (frame_wrap ? '0 : frame_cnt + FRAME_CNT_W'(1));

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_cnt <= '0;
            o_clk_pin <= 1'b0;
            o_clk_pin_oe <= 1'b0;
            clk_pin_prev <= 1'b0;
        end else begin
            div_cnt <= int_tick ? '0 : div_cnt + DIV_W'(1);
            if (int_tick || div_cnt == DIV_HALF) begin
                o_clk_pin <= ~o_clk_pin;
            end
            o_clk_pin_oe <= ~i_osc_source_select;
            clk_pin_prev <= i_clk_pin;
        end
    end

    // ------------------------------------------------------------------
    // Frame counter and sync pin
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            frame_cnt <= '0;
            pol <= 1'b0;
            step <= 1'b0;
            o_sync <= 1'b0;
            o_sync_oe <= 1'b0;
        end else begin
            step <= tick;
            o_sync <= 1'b0;
            if (tick) begin
                frame_cnt <= next_frame_cnt;
                pol <= (frame_wrap && !sync_pull) ? ~pol : pol;
                o_sync_oe <= (next_frame_cnt == '0);
            end
        end
    end

    assign o_frame = '{step: step, pol: pol, cnt: frame_cnt};

endmodule : lcd_clock_timing

/* File: rtl/lcd_mux_ram_loader.sv */
// LCD segment driver core: AXI4-Lite command port, display RAM and multiplexer
module lcd_mux_ram_loader
    import lcd_pkg::*;
#(
    parameter int INT_DIV = INT_CLK_DIV
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_axi_awaddr,
    input wire logic i_axi_awvalid,
    output logic o_axi_awready,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    input wire logic i_axi_wvalid,
    output logic o_axi_wready,
    output logic [1:0] o_axi_bresp,
    output logic o_axi_bvalid,
    input wire logic i_axi_bready,
    input wire logic [ADDR_W-1:0] i_axi_araddr,
    input wire logic i_axi_arvalid,
    output logic o_axi_arready,
    output logic [31:0] o_axi_rdata,
    output logic [1:0] o_axi_rresp,
    output logic o_axi_rvalid,
    input wire logic i_axi_rready,
    input wire logic i_osc_source_select,
    input wire logic i_clk_pin,
    output logic o_clk_pin,
    output logic o_clk_pin_oe,
    input wire logic i_sync,
    output logic o_sync,
    output logic o_sync_oe,
    input wire logic i_hw_subaddr_bit0,
    input wire logic i_hw_subaddr_bit1,
    input wire logic i_hw_subaddr_bit2,
    output logic o_backplane_out_0,
    output logic o_backplane_out_1,
    output logic o_backplane_out_2,
    output logic o_backplane_out_3,
    output logic [NUM_COLS-1:0] o_segment_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [7:0] last_byte;
    xfer_state_e xfer;
    drive_mode_e mode;
    logic disp_en;
    logic [COL_W-1:0] ptr;
    logic [2:0] subaddr;
    logic last_ack;
    logic [NUM_ROWS-1:0] disp_ram [NUM_COLS];
    logic [NUM_COLS-1:0] disp_latch;
    logic [1:0] cur_slot;
    logic [NUM_ROWS-1:0] bp_q;
    frame_s frame;

    // ------------------------------------------------------------------
    // Timing block
    // ------------------------------------------------------------------
    lcd_clock_timing #(
        .INT_DIV(INT_DIV)
    ) u_timing (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_osc_source_select(i_osc_source_select),
        .i_clk_pin(i_clk_pin),
        .i_sync(i_sync),
        .o_frame(frame),
        .o_clk_pin(o_clk_pin),
        .o_clk_pin_oe(o_clk_pin_oe),
        .o_sync(o_sync),
        .o_sync_oe(o_sync_oe)
    );

    // ------------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------------
    wire do_write = aw_held & w_held & ~o_axi_bvalid;
    wire wr_byte_hit = (wr_addr == ADDR_BYTE);
    wire wr_ctrl_hit = (wr_addr == ADDR_CTRL);
    wire wr_ok = wr_byte_hit | wr_ctrl_hit;
    wire byte_wr = do_write & wr_byte_hit & wr_strb[0];
    wire start_wr = do_write & wr_ctrl_hit & wr_strb[0] & wr_data[CTRL_START_BIT];
    wire [7:0] rx_byte = wr_data[7:0];
    wire rd_take = i_axi_arvalid & o_axi_arready;
    wire rd_status_hit = (i_axi_araddr == ADDR_STATUS);
    wire rd_byte_hit = (i_axi_araddr == ADDR_BYTE);
    wire rd_ctrl_hit = (i_axi_araddr == ADDR_CTRL);
    wire rd_ok = rd_status_hit | rd_byte_hit | rd_ctrl_hit;

    logic [31:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[ST_PTR_LSB +: COL_W] = ptr;
        status_word[ST_SUB_LSB +: 3] = subaddr;
        status_word[ST_MODE_LSB +: 2] = mode;
        status_word[ST_EN_BIT] = disp_en;
        status_word[ST_DATA_BIT] = (xfer == XS_DATA);
        status_word[ST_ACK_BIT] = last_ack;
        status_word[ST_EXT_BIT] = i_osc_source_select;
    end

    wire [31:0] rd_word = rd_status_hit ? status_word : (rd_byte_hit ? {24'h000000, last_byte} : 32'h00000000);

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
            o_axi_awready <= 1'b0;
            o_axi_wready <= 1'b0;
            o_axi_bvalid <= 1'b0;
            o_axi_bresp <= RESP_OKAY;
        end else begin
            o_axi_awready <= ~aw_held & ~(i_axi_awvalid & o_axi_awready) & ~o_axi_bvalid;
            o_axi_wready <= ~w_held & ~(i_axi_wvalid & o_axi_wready) & ~o_axi_bvalid;
            if (i_axi_awvalid && o_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= i_axi_awaddr;
            end
            if (i_axi_wvalid && o_axi_wready) begin
                w_held <= 1'b1;
                wr_data <= i_axi_wdata;
                wr_strb <= i_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                o_axi_bvalid <= 1'b1;
                o_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (o_axi_bvalid && i_axi_bready) begin
                o_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_axi_arready <= 1'b0;
            o_axi_rvalid <= 1'b0;
            o_axi_rdata <= '0;
            o_axi_rresp <= RESP_OKAY;
        end else begin
            o_axi_arready <= ~o_axi_rvalid & ~rd_take;
            if (rd_take) begin
                o_axi_rvalid <= 1'b1;
                o_axi_rdata <= rd_word;
                o_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (o_axi_rvalid && i_axi_rready) begin
                o_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Byte placement per drive mode
    // ------------------------------------------------------------------
    logic [2:0] rows_per_col;
    logic [3:0] ptr_step;
    always_comb begin
        case (mode)
            MODE_STATIC: begin
                rows_per_col = 3'h1;
                ptr_step = 4'h8;
            end
            MODE_MUX2: begin
                rows_per_col = 3'h2;
                ptr_step = 4'h4;
            end
            MODE_MUX3: begin
                rows_per_col = 3'h3;
                ptr_step = 4'h3;
            end
            default: begin
                rows_per_col = 3'h4;
                ptr_step = 4'h2;
            end
        endcase
    end

    wire [2:0] hw_subaddr = {i_hw_subaddr_bit2, i_hw_subaddr_bit1, i_hw_subaddr_bit0};
    wire [2:0] subaddr_plus = subaddr + 3'h1;
    wire [COL_W:0] ptr_sum = {1'b0, ptr} + {3'h0, ptr_step};
    wire ptr_over = (ptr_sum >= (COL_W + 1)'(NUM_COLS));
    wire [COL_W:0] ptr_wrapped = ptr_over ? ptr_sum - (COL_W + 1)'(NUM_COLS) : ptr_sum;

    logic [NUM_ROWS-1:0] col_we [NUM_COLS];
    logic [NUM_ROWS-1:0] col_wd [NUM_COLS];
    logic [NUM_COLS-1:0] col_hit;
    logic [NUM_COLS-1:0] row_bits [NUM_ROWS];

    genvar gc, gr;
    generate
        for (gc = 0; gc < NUM_COLS; gc++) begin : g_col
            localparam logic [COL_W-1:0] COL_IDX = COL_W'(gc);
            wire wrap = (COL_IDX < ptr);
            wire [COL_W-1:0] off = wrap ? COL_IDX + COL_W'(NUM_COLS) - ptr : COL_IDX - ptr;
            wire match = ((wrap ? subaddr_plus : subaddr) == hw_subaddr);
            for (gr = 0; gr < NUM_ROWS; gr++) begin : g_row
                wire [7:0] bit_idx = 8'(off) * 8'(rows_per_col) + 8'(gr);
                wire in_byte = (bit_idx < 8'h08) && (3'(gr) < rows_per_col);
                assign col_we[gc][gr] = in_byte & match;
                assign col_wd[gc][gr] = rx_byte[3'h7 - bit_idx[2:0]];
                assign row_bits[gr][gc] = disp_ram[gc][gr];
            end
            assign col_hit[gc] = |col_we[gc];
        end
    endgenerate

    wire data_byte = byte_wr & (xfer == XS_DATA);
    wire cmd_byte = byte_wr & (xfer == XS_CMD);

    always_ff @(posedge i_clk_sys) begin
        for (int c = 0; c < NUM_COLS; c++) begin
            if (data_byte) begin
                disp_ram[c] <= (disp_ram[c] & ~col_we[c]) | (col_wd[c] & col_we[c]);
            end
        end
    end

    // ------------------------------------------------------------------
    // Command decoder, pointer and subaddress counter
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            xfer <= XS_IDLE;
            mode <= RESET_MODE;
            disp_en <= 1'b0;
            ptr <= '0;
            subaddr <= '0;
            last_ack <= 1'b0;
            last_byte <= '0;
        end else begin
            if (byte_wr) begin
                last_byte <= rx_byte;
            end
            if (start_wr) begin
                xfer <= XS_CMD;
            end else if (cmd_byte) begin
                last_ack <= 1'b1;
                xfer <= rx_byte[CMD_CONT_BIT] ? XS_CMD : XS_DATA;
                if (!rx_byte[CMD_PTR_SEL_BIT]) begin
                    ptr <= rx_byte[COL_W-1:0];
                end else if (rx_byte[6:5] == CMD_MODE_SET) begin
                    mode <= drive_mode_e'(rx_byte[1:0]);
                    disp_en <= rx_byte[CMD_EN_BIT];
                end else if (rx_byte[6:3] == CMD_DEV_SEL) begin
                    subaddr <= rx_byte[2:0];
                end
            end else if (data_byte) begin
                last_ack <= |col_hit;
                ptr <= ptr_wrapped[COL_W-1:0];
                if (ptr_over) begin
                    subaddr <= subaddr_plus;
                end
            end else if (byte_wr) begin
                last_ack <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Multiplex phase and display latch
    // ------------------------------------------------------------------
    logic [FRAME_CNT_W-1:0] slot_len;
    always_comb begin
        case (mode)
            MODE_STATIC: slot_len = 5'h18;
            MODE_MUX2: slot_len = 5'h0C;
            MODE_MUX3: slot_len = 5'h08;
            default: slot_len = 5'h06;
        endcase
    end

    wire [FRAME_CNT_W-1:0] slot_idx_w = frame.cnt / slot_len;
    wire [1:0] slot_idx = slot_idx_w[1:0];
    wire [FRAME_CNT_W-1:0] slot_base = 5'(slot_idx_w * slot_len);
    wire slot_begin = frame.step & (frame.cnt == slot_base);

    logic [NUM_ROWS-1:0] bp_active;
    always_comb begin
        case (mode)
            MODE_STATIC: bp_active = 4'hF;
            MODE_MUX2: bp_active = (slot_idx == 2'h0) ? 4'h5 : 4'hA;
            MODE_MUX3: bp_active = (slot_idx == 2'h1) ? 4'hA : 4'(1 << slot_idx);
            default: bp_active = 4'(1 << slot_idx);
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            disp_latch <= '0;
            cur_slot <= '0;
            bp_q <= '0;
        end else if (slot_begin) begin
            disp_latch <= row_bits[slot_idx];
            cur_slot <= slot_idx;
            bp_q <= bp_active;
        end
    end

    // ------------------------------------------------------------------
    // Output drive: on element differs from its backplane level
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_segment_out <= '0;
            o_backplane_out_0 <= 1'b0;
            o_backplane_out_1 <= 1'b0;
            o_backplane_out_2 <= 1'b0;
            o_backplane_out_3 <= 1'b0;
        end else if (!disp_en) begin
            o_segment_out <= '0;
            o_backplane_out_0 <= 1'b0;
            o_backplane_out_1 <= 1'b0;
            o_backplane_out_2 <= 1'b0;
            o_backplane_out_3 <= 1'b0;
        end else begin
            o_segment_out <= disp_latch ^ {NUM_COLS{frame.pol}};
            o_backplane_out_0 <= ~bp_q[0] ^ frame.pol;
            o_backplane_out_1 <= ~bp_q[1] ^ frame.pol;
            o_backplane_out_2 <= ~bp_q[2] ^ frame.pol;
            o_backplane_out_3 <= ~bp_q[3] ^ frame.pol;
        end
    end

endmodule : lcd_mux_ram_loader

/* File: sim/lcd_loader_sva.sv */
// Assertion checker for the LCD multiplex RAM loader
module lcd_loader_sva
    import lcd_pkg::*;
#(
    parameter int INT_DIV = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_osc_source_select,
    input wire logic i_sync,
    input wire logic i_axi_bready,
    input wire logic o_clk_pin,
    input wire logic o_clk_pin_oe,
    input wire logic o_sync,
    input wire logic o_sync_oe,
    input wire logic o_axi_awready,
    input wire logic o_axi_wready,
    input wire logic o_axi_bvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // ------------------------------------------------------------
    // Spans between rises of clock pin and sync pull
    // ------------------------------------------------------------
    int clk_span;
    int fr_span;
    logic clk_ok;
    logic fr_seen;
    logic fr_ok;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clk_span <= 0;
            fr_span <= 0;
            clk_ok <= 1'b0;
            fr_seen <= 1'b0;
            fr_ok <= 1'b0;
        end else begin
            clk_span <= $rose(o_clk_pin) ? 0 : clk_span + 1;
            fr_span <= $rose(o_sync_oe) ? 0 : fr_span + 1;
            clk_ok <= (clk_ok | $rose(o_clk_pin)) & o_clk_pin_oe;
            fr_seen <= (fr_seen | $rose(o_sync_oe)) & !i_osc_source_select & (i_sync | o_sync_oe);
            fr_ok <= (fr_ok | ($rose(o_sync_oe) & fr_seen)) & !i_osc_source_select & (i_sync | o_sync_oe);
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_int_steady;
        !i_osc_source_select [*3];
    endsequence
    sequence s_ext_steady;
        i_osc_source_select [*3];
    endsequence
    a_int_clk_drive: assert property (s_int_steady |-> o_clk_pin_oe)
        else $error("clock pin not driven");
    a_ext_clk_input: assert property (s_ext_steady |-> !o_clk_pin_oe)
        else $error("clock pin driven in external mode");
    a_int_clk_period: assert property ($rose(o_clk_pin) && clk_ok |-> clk_span == INT_DIV - 1)
        else $error("clock pin period wrong");
    a_frame_period: assert property ($rose(o_sync_oe) && fr_ok |-> fr_span == FRAME_DIV * INT_DIV - 1)
        else $error("frame period wrong");
    a_sync_width: assert property ($rose(o_sync_oe) |-> o_sync_oe [*4])
        else $error("sync pulse too short");
    a_sync_open_drain: assert property (o_sync_oe |-> !o_sync)
        else $error("sync driven high");
    a_write_refuse: assert property (o_axi_bvalid |-> !o_axi_awready && !o_axi_wready)
        else $error("write taken while response pending");
    a_bvalid_drop: assert property ($rose(o_axi_bvalid) && i_axi_bready |=> !o_axi_bvalid)
        else $error("write response held too long");
endmodule : lcd_loader_sva

bind lcd_mux_ram_loader lcd_loader_sva #(.INT_DIV(INT_DIV)) lcd_loader_sva_inst (
    .i_clk_sys, .i_rst_n, .i_osc_source_select, .i_sync, .i_axi_bready, .o_clk_pin,
    .o_clk_pin_oe, .o_sync, .o_sync_oe, .o_axi_awready, .o_axi_wready, .o_axi_bvalid
);

/* File: sim/cascade_peer.sv */
// Cascade peer model: external clock source and second sync puller
module cascade_peer #(
    parameter int HALF = 5
) (
    input wire logic i_clk_sys,
    input wire logic i_run,
    input wire logic i_pull,
    output logic o_clk,
    output logic o_sync_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial o_clk = 1'b0;
    // Clock stands still unless selected as source
    always @(posedge i_clk_sys) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) o_clk <= i_run ? ~o_clk : 1'b0;
    end
    assign o_sync_oe = i_pull;
endmodule : cascade_peer

/* File: sim/tb_top.sv */
// Self-checking bench for the LCD multiplex RAM loader
module tb_top
    import lcd_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk_sys = 0, i_rst_n = 0, i_axi_awvalid = 0, i_axi_wvalid = 0, i_axi_bready = 0;
    logic i_axi_arvalid = 0, i_axi_rready = 0, i_osc_source_select = 0, peer_pull = 0;
    logic [7:0] i_axi_awaddr = '0, i_axi_araddr = '0;
    logic [31:0] i_axi_wdata = '0, st, o_axi_rdata;
    logic [2:0] pins = 3'h2;
    logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid, o_clk_pin, o_clk_pin_oe;
    logic o_sync, o_sync_oe, peer_clk, peer_oe, i_clk_pin, i_sync;
    logic o_backplane_out_0, o_backplane_out_1, o_backplane_out_2, o_backplane_out_3;
    logic [1:0] o_axi_bresp, o_axi_rresp, resp;
    logic [39:0] o_segment_out;
    logic [3:0] exp_bp;
    wire [3:0] bp = {o_backplane_out_3, o_backplane_out_2, o_backplane_out_1, o_backplane_out_0};
    int n_checks = 0, n_mismatch = 0;
    typedef struct packed {logic [2:0] ds; logic [1:0] m; logic [5:0] p, ep; logic [2:0] es; logic ack;} row_s;
    row_s rows [6] = '{'{3'h2, 2'h1, 6'h00, 6'h08, 3'h2, 1'b1}, '{3'h2, 2'h2, 6'h26, 6'h02, 3'h3, 1'b1},
        '{3'h2, 2'h3, 6'h27, 6'h02, 3'h3, 1'b1}, '{3'h2, 2'h0, 6'h26, 6'h00, 3'h3, 1'b1},
        '{3'h3, 2'h0, 6'h00, 6'h02, 3'h3, 1'b0}, '{3'h1, 2'h1, 6'h24, 6'h04, 3'h2, 1'b1}};
    assign i_clk_pin = o_clk_pin_oe ? o_clk_pin : peer_clk;
    assign i_sync = !(o_sync_oe | peer_oe);
    always #25 i_clk_sys = ~i_clk_sys;
    lcd_mux_ram_loader #(.INT_DIV(8)) lcd_mux_ram_loader_inst (
        .i_clk_sys, .i_rst_n, .i_axi_awaddr, .i_axi_awvalid, .o_axi_awready, .i_axi_wdata,
        .i_axi_wstrb(4'hF), .i_axi_wvalid, .o_axi_wready, .o_axi_bresp, .o_axi_bvalid, .i_axi_bready,
        .i_axi_araddr, .i_axi_arvalid, .o_axi_arready, .o_axi_rdata, .o_axi_rresp, .o_axi_rvalid,
        .i_axi_rready, .i_osc_source_select, .i_clk_pin, .o_clk_pin, .o_clk_pin_oe, .i_sync, .o_sync,
        .o_sync_oe, .i_hw_subaddr_bit0(pins[0]), .i_hw_subaddr_bit1(pins[1]), .i_hw_subaddr_bit2(pins[2]),
        .o_backplane_out_0, .o_backplane_out_1, .o_backplane_out_2, .o_backplane_out_3, .o_segment_out
    );
    cascade_peer cascade_peer_inst (.i_clk_sys, .i_run(i_osc_source_select), .i_pull(peer_pull),
        .o_clk(peer_clk), .o_sync_oe(peer_oe));
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic done;
        done = 1'b0;
        i_axi_awaddr <= a;
        i_axi_wdata <= {24'h000000, d};
        i_axi_awvalid <= 1'b1;
        i_axi_wvalid <= 1'b1;
        i_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge i_clk_sys);
            if (o_axi_awready) i_axi_awvalid <= 1'b0;
            if (o_axi_wready) i_axi_wvalid <= 1'b0;
            done = o_axi_bvalid;
            resp = o_axi_bresp;
        end
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic done;
        done = 1'b0;
        i_axi_araddr <= a;
        i_axi_arvalid <= 1'b1;
        i_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge i_clk_sys);
            if (o_axi_arready) i_axi_arvalid <= 1'b0;
            done = o_axi_rvalid;
            st = o_axi_rdata;
            resp = o_axi_rresp;
        end
    endtask : rd
    task automatic send(input logic [2:0] ds, input logic [1:0] m, input logic [5:0] p);
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_BYTE, {1'b1, CMD_DEV_SEL, ds});
        wr(ADDR_BYTE, {1'b1, CMD_MODE_SET, 2'h1, 1'b0, m});
        wr(ADDR_BYTE, {2'h0, p});
    endtask : send
    task automatic do_reset();
        i_rst_n <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        rd(ADDR_STATUS);
        chk(st & 32'h003F_073F, 32'h0, "reset status");
    endtask : do_reset
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // Sequence of tests
    // ------------------------------------------------------------
    initial begin
        do_reset();
        chk({28'h0, bp}, 32'h0, "blank backplanes");
        rd(8'h0C);
        chk({st[29:0], resp}, {30'h0, RESP_SLVERR}, "unmapped read");
        wr(8'h0C, 8'h00);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
        foreach (rows[i]) begin
            send(rows[i].ds, rows[i].m, rows[i].p);
            wr(ADDR_BYTE, 8'hA5);
            rd(ADDR_STATUS);
            chk(st & 32'h003F_073F, {10'h000, 1'b0, rows[i].ack, 2'h3, rows[i].m, 5'h00, rows[i].es, 2'h0,
                rows[i].ep}, "row status");
            repeat (200) @(posedge i_clk_sys);
            repeat (30) begin
                repeat (7) @(posedge i_clk_sys);
                exp_bp = (rows[i].m == 2'h1) ? {4{bp[0]}} : (rows[i].m == 2'h2) ? {2{bp[1:0]}}
                    : (rows[i].m == 2'h3) ? {bp[1], bp[2:0]} : bp ^ {3'h0, ~^bp};
                chk({28'h0, bp}, {28'h0, exp_bp}, "backplanes");
            end
            $display("row %0d done", i);
        end
        send(3'h2, 2'h1, 6'h00);
        wr(ADDR_BYTE, 8'hB4);
        wr(ADDR_BYTE, 8'h00);
        repeat (2) begin
            repeat (200) @(posedge i_clk_sys);
            chk({16'h0, o_segment_out[15:0] ^ {16{bp[0]}}}, 32'h002D, "static segments");
        end
        $display("static data done");
        i_osc_source_select <= 1'b1;
        repeat (600) @(posedge i_clk_sys);
        rd(ADDR_STATUS);
        chk({31'h0, st[21]}, 32'h1, "external select");
        peer_pull <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        peer_pull <= 1'b0;
        repeat (300) @(posedge i_clk_sys);
        i_osc_source_select <= 1'b0;
        repeat (600) @(posedge i_clk_sys);
        $display("clock source done");
        do_reset();
        $display("second reset done");
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : tb_top
